// ### core/mcp_pkg.sv
// package: constants and carrier types for the controller-side cache memory port
package mcp_pkg;

  localparam int ADDR_W   = 22;
  localparam int DATA_W   = 32;
  localparam int PAR_W    = 4;
  localparam int BUS_W    = DATA_W + PAR_W;

  // control line encodings driven by the controller
  localparam logic CTL_READ      = 1'h0;
  localparam logic CTL_WRITE     = 1'h1;
  localparam logic CTL_NO_PAUSE  = 1'h0;
  localparam logic CTL_SINGLE    = 1'h0;
  localparam logic CTL_DOUBLE    = 1'h1;

  // control lines of one transfer
  typedef struct packed {
    logic direction_ctl;
    logic byte_pause_ctl;
    logic double_word_ctl;
  } mcp_ctl_t;

  localparam mcp_ctl_t CTL_IDLE = 3'h0;

  // user-side transfer request
  typedef struct packed {
    logic              write;
    logic              dbl;
    logic [ADDR_W-1:0] addr;
  } mcp_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_REQ  = 3'h2,
    ST_XFER = 3'h4
  } mcp_state_t;

endpackage : mcp_pkg

// ### core/mcp_port.sv
// module: controller end of the shared cache memory port
`timescale 1ns/1ps
`default_nettype none

module mcp_port #(
  parameter int ADDR_W = mcp_pkg::ADDR_W,
  parameter int BUS_W  = mcp_pkg::BUS_W
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  // user side
  input  wire logic              start,
  input  wire mcp_pkg::mcp_req_t req_in,
  input  wire logic [BUS_W-1:0]  wr_data,
  input  wire logic              wr_last,
  output logic                   busy,
  output logic                   done,
  output logic [BUS_W-1:0]       rd_data,
  output logic                   rd_valid,
  // cache side
  output logic                   mem_req,
  input  wire logic              mem_ack,
  input  wire logic              addr_sel,
  input  wire logic              data_sel,
  input  wire logic              xfer_end,
  output logic [ADDR_W-1:0]      bus_addr,
  output logic                   bus_addr_oe,
  output mcp_pkg::mcp_ctl_t      bus_ctl,
  output logic [BUS_W-1:0]       bus_data_o,
  output logic                   bus_data_oe,
  input  wire logic [BUS_W-1:0]  bus_data_i
);

  // ==========================================================
  // control encoding
  // ==========================================================
  mcp_pkg::mcp_state_t state_q, state_d;
  mcp_pkg::mcp_req_t   req_q;
  mcp_pkg::mcp_ctl_t   ctl_q;
  wire mcp_pkg::mcp_ctl_t ctl_new;
  wire                    is_write;

  function automatic mcp_pkg::mcp_ctl_t encode(input mcp_pkg::mcp_req_t r);
    mcp_pkg::mcp_ctl_t c;
    c.byte_pause_ctl  = mcp_pkg::CTL_NO_PAUSE;
    c.direction_ctl   = r.write ? mcp_pkg::CTL_WRITE : mcp_pkg::CTL_READ;
    // reads are always double-word yet go out with the size line low
    c.double_word_ctl = r.write ? r.dbl : mcp_pkg::CTL_SINGLE;
    return c;
  endfunction : encode

  assign ctl_new  = encode(req_in);
  assign is_write = req_q.write;

  // ==========================================================
  // sequencer
  // ==========================================================
  always_comb begin
    state_d = state_q;
    case (state_q)
      mcp_pkg::ST_IDLE: begin
        // start is only taken from idle, a start while busy is dropped
        if (start)
          state_d = mcp_pkg::ST_REQ;
      end
      mcp_pkg::ST_REQ: begin
        if (mem_ack)
          state_d = mcp_pkg::ST_XFER;
      end
      mcp_pkg::ST_XFER: begin
        if (xfer_end)
          state_d = mcp_pkg::ST_IDLE;
      end
      default: state_d = mcp_pkg::ST_IDLE;
    endcase
  end

  wire take_start = (state_q == mcp_pkg::ST_IDLE) && start;
  wire in_xfer    = (state_q == mcp_pkg::ST_XFER);
  wire addr_gate  = in_xfer && addr_sel;
  wire drive_data = in_xfer && data_sel && is_write;
  wire grab_data  = in_xfer && data_sel && !is_write;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q <= mcp_pkg::ST_IDLE;
      req_q   <= '0;
      ctl_q   <= mcp_pkg::CTL_IDLE;
    end else begin
      state_q <= state_d;
      // request and encoding are loaded only on an accepted start and held until the next one
      if (take_start) begin
        req_q <= req_in;
        ctl_q <= ctl_new;
      end
    end
  end

  // ==========================================================
  // bus drive
  // ==========================================================
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mem_req     <= 1'h0;
      busy        <= 1'h0;
      done        <= 1'h0;
      bus_addr    <= '0;
      bus_addr_oe <= 1'h0;
      bus_ctl     <= mcp_pkg::CTL_IDLE;
      bus_data_o  <= '0;
      bus_data_oe <= 1'h0;
      rd_data     <= '0;
      rd_valid    <= 1'h0;
    end else begin
      // request held until acknowledge, then dropped
      mem_req     <= (state_d == mcp_pkg::ST_REQ);
      busy        <= (state_d != mcp_pkg::ST_IDLE);
      done        <= in_xfer && xfer_end;
      // address and control lines read zero whenever they are not gated
      bus_addr_oe <= addr_gate;
      bus_addr    <= addr_gate ? req_q.addr : '0;
      bus_ctl     <= addr_gate ? ctl_q : mcp_pkg::CTL_IDLE;
      bus_data_oe <= drive_data;
      bus_data_o  <= drive_data ? wr_data : '0;
      rd_valid    <= grab_data;
      if (grab_data)
        rd_data <= bus_data_i;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  // control line encoding
  pause_low_a: assert property (@(posedge clk_sys) disable iff (reset)
    !bus_ctl.byte_pause_ctl)
    else $error("pause line asserted");

  read_enc_a: assert property (@(posedge clk_sys) disable iff (reset)
    (bus_addr_oe && !bus_ctl.direction_ctl) |-> (bus_ctl == mcp_pkg::CTL_IDLE))
    else $error("read encoding wrong");

  write_enc_a: assert property (@(posedge clk_sys) disable iff (reset)
    (bus_addr_oe && req_q.write) |->
      (bus_ctl.direction_ctl == mcp_pkg::CTL_WRITE && !bus_ctl.byte_pause_ctl))
    else $error("write encoding wrong");

  dir_match_a: assert property (@(posedge clk_sys) disable iff (reset)
    bus_addr_oe |-> (bus_ctl.direction_ctl == req_q.write))
    else $error("direction mismatch");

  write_dbl_a: assert property (@(posedge clk_sys) disable iff (reset)
    (bus_addr_oe && bus_ctl.direction_ctl) |-> (bus_ctl.double_word_ctl == req_q.dbl))
    else $error("write size mismatch");

  // request handshake
  req_start_a: assert property (@(posedge clk_sys) disable iff (reset)
    take_start |=> mem_req)
    else $error("request not raised");

  req_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    (mem_req && !mem_ack) |=> mem_req)
    else $error("request dropped early");

  req_release_a: assert property (@(posedge clk_sys) disable iff (reset)
    (mem_req && mem_ack) |=> !mem_req)
    else $error("request not released");

  req_state_a: assert property (@(posedge clk_sys) disable iff (reset)
    mem_req == (state_q == mcp_pkg::ST_REQ))
    else $error("request outside request state");

  busy_req_a: assert property (@(posedge clk_sys) disable iff (reset)
    mem_req |-> busy)
    else $error("request while not busy");

  done_end_a: assert property (@(posedge clk_sys) disable iff (reset)
    (in_xfer && xfer_end) |=> done)
    else $error("end of cycle not reported");

  done_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
    done |-> !busy)
    else $error("busy at end of cycle");

  // address, control and data gating
  addr_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
    addr_gate |=> (bus_addr_oe && bus_addr == $past(req_q.addr)))
    else $error("address not driven");

  addr_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
    !bus_addr_oe |-> (bus_addr == '0 && bus_ctl == mcp_pkg::CTL_IDLE))
    else $error("address lines not quiet");

  sel_ignore_a: assert property (@(posedge clk_sys) disable iff (reset)
    !in_xfer |=> (!bus_addr_oe && !bus_data_oe && !rd_valid))
    else $error("select taken outside a cycle");

  data_dir_a: assert property (@(posedge clk_sys) disable iff (reset)
    !(bus_data_oe && rd_valid))
    else $error("data drive and capture together");

  wr_drive_a: assert property (@(posedge clk_sys) disable iff (reset)
    drive_data |=> (bus_data_oe && bus_data_o == $past(wr_data)))
    else $error("write data not driven");

  data_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
    !bus_data_oe |-> (bus_data_o == '0))
    else $error("data lines not quiet");

  rd_capture_a: assert property (@(posedge clk_sys) disable iff (reset)
    grab_data |=> (rd_valid && rd_data == $past(bus_data_i)))
    else $error("read data not captured");

endmodule : mcp_port

`default_nettype wire

// ### sim/mcp_cache_model.sv
// file: behavioural cache arbiter and memory partner
`timescale 1ns/1ps
`default_nettype none
module mcp_cache_model (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        mem_req,
  input  wire logic [3:0]  wait_n,
  input  wire logic [1:0]  n_words,
  input  wire logic [35:0] rd_word,
  output logic             mem_ack,
  output logic             addr_sel,
  output logic             data_sel,
  output logic             xfer_end,
  output logic [35:0]      bus_data_i
);
  // ==========================================
  // sole requester here, so grant after wait_n
  initial begin
    {mem_ack, addr_sel, data_sel, xfer_end} = 4'h0;
    bus_data_i = 36'h0;
    forever begin
      @(posedge clk_sys);
      if (!reset && mem_req) begin
        repeat (wait_n) @(posedge clk_sys);
        #1 mem_ack = 1'h1;
        @(posedge clk_sys);
        #1 mem_ack = 1'h0;
        addr_sel = 1'h1;
        @(posedge clk_sys);
        #1 addr_sel = 1'h0;
        // strobe stays up across the words of a double transfer
        data_sel = 1'h1;
        for (int i = 0; i < n_words; i++) begin
          bus_data_i = rd_word + 36'(i);
          @(posedge clk_sys);
          #1;
        end
        // released data lines show the inverse of the last word
        data_sel = 1'h0;
        bus_data_i = ~bus_data_i;
        // pass-through only, nothing held or filled
        xfer_end = 1'h1;
        @(posedge clk_sys);
        #1 xfer_end = 1'h0;
      end
    end
  end
endmodule : mcp_cache_model
`default_nettype wire

// ### sim/mcp_port_test.sv
// file: self-checking bench for the cache memory port
`timescale 1ns/1ps
`default_nettype none
module mcp_port_test;
  logic clk_sys = 1'h0, reset = 1'h1, start = 1'h0, wr_last = 1'h0;
  logic busy, done, rd_valid, mem_req, mem_ack, addr_sel, data_sel;
  logic xfer_end, bus_addr_oe, bus_data_oe, prev_req, prev_ack;
  logic [35:0] wr_data = 36'h0, rd_word = 36'h0, rd_data, bus_data_o, bus_data_i;
  logic [21:0] bus_addr, seen_addr;
  logic [3:0]  wait_n = 4'h0;
  logic [1:0]  n_words = 2'h1;
  mcp_pkg::mcp_req_t req_in = '0;
  mcp_pkg::mcp_ctl_t bus_ctl, seen_ctl;
  int fail_count = 0, checks_done = 0, cycles = 0, n_rd = 0, n_wr = 0;
  mcp_port uut (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .start       (start),
    .req_in      (req_in),
    .wr_data     (wr_data),
    .wr_last     (wr_last),
    .busy        (busy),
    .done        (done),
    .rd_data     (rd_data),
    .rd_valid    (rd_valid),
    .mem_req     (mem_req),
    .mem_ack     (mem_ack),
    .addr_sel    (addr_sel),
    .data_sel    (data_sel),
    .xfer_end    (xfer_end),
    .bus_addr    (bus_addr),
    .bus_addr_oe (bus_addr_oe),
    .bus_ctl     (bus_ctl),
    .bus_data_o  (bus_data_o),
    .bus_data_oe (bus_data_oe),
    .bus_data_i  (bus_data_i)
  );
  mcp_cache_model cache (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .mem_req    (mem_req),
    .wait_n     (wait_n),
    .n_words    (n_words),
    .rd_word    (rd_word),
    .mem_ack    (mem_ack),
    .addr_sel   (addr_sel),
    .data_sel   (data_sel),
    .xfer_end   (xfer_end),
    .bus_data_i (bus_data_i)
  );
  always #20 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [63:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // ==========================================
  // bus monitor
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      close_out();
    end
    if (!reset) chk("pause", 0, bus_ctl.byte_pause_ctl);
    if (!reset && prev_req && !mem_req) chk("req_hold", 1, prev_ack);
    prev_req = mem_req;
    prev_ack = mem_ack;
    if (start) begin
      seen_ctl = '1;
      seen_addr = '1;
      n_rd = 0;
      n_wr = 0;
    end
    if (bus_addr_oe) {seen_ctl, seen_addr} = {bus_ctl, bus_addr};
    if (rd_valid) begin
      chk("rd_data", rd_word + 36'(n_rd), rd_data);
      n_rd++;
    end
    if (bus_data_oe) chk("wr_data", wr_data, bus_data_o);
    if (bus_data_oe) n_wr++;
  end
  task automatic xfer(input logic w, d, input logic [21:0] a, input logic [2:0] c);
    int k;
    k = 0;
    req_in = '{write: w, dbl: d, addr: a};
    start = 1'h1;
    @(posedge clk_sys);
    #1 start = 1'h0;
    chk("busy", 1, busy);
    while (done !== 1'h1 && k < 60) begin
      @(posedge clk_sys);
      #1 k++;
    end
    chk("done", 1, done);
    chk("busy", 0, busy);
    chk("ctl", c, seen_ctl);
    chk("addr", a, seen_addr);
  endtask : xfer
  // ==========================================
  // scenarios
  task automatic t_read;
    n_words = 2'h2;
    rd_word = 36'hA5A5A5A5F;
    xfer(1'h0, 1'h0, 22'h3FFFFF, 3'h0);
    chk("reads", 2, n_rd);
  endtask : t_read
  task automatic t_read_slow;
    wait_n = 4'h5;
    xfer(1'h0, 1'h1, 22'h000000, 3'h0);
    wait_n = 4'h0;
  endtask : t_read_slow
  task automatic t_wr_single;
    n_words = 2'h1;
    wr_data = 36'h9C3F0E1D2;
    xfer(1'h1, 1'h0, 22'h155555, 3'h4);
    chk("writes", 1, n_wr);
  endtask : t_wr_single
  task automatic t_wr_double;
    n_words = 2'h2;
    xfer(1'h1, 1'h1, 22'h2AAAAA, 3'h5);
    chk("writes", 2, n_wr);
  endtask : t_wr_double
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 reset = 1'h0;
    t_read();
    t_read_slow();
    t_wr_single();
    t_wr_double();
    close_out();
  end
endmodule : mcp_port_test
`default_nettype wire
